/* File: verilog/sra_pkg.sv */
// Shared constants for the two-wire register access link
package sra_pkg;
   localparam logic [6:0] TARGET_ADDR = 7'h47;
   localparam int REG_ADDR_W = 16;
   localparam int DATA_W = 16;
   // Table space: accesses that start at or above this base do not auto-advance
   localparam logic [15:0] TABLE_BASE = 16'hc000;
   // Master serial clock half period in clk cycles (50 MHz / 200 kHz / 2)
   localparam int HALF_PERIOD = 125;
   localparam logic [7:0] HALF_PERIOD_8 = 8'h7d;
endpackage

/* File: verilog/sra_if.sv */
// Two-wire link between the register access host and the device port
`timescale 1ns/100ps
interface sra_if;
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   wire scl;
   wire sda;
   // Wired-AND: any driver that is enabled and low pulls the line low
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
   modport host (input scl, input sda, output scl_o, output scl_oe,
      output sda_m_o, output sda_m_oe);
endinterface

/* File: verilog/sra_device.sv */
// Device end: two-wire target that reads and writes 16-bit registers
// Notes on behaviour
// - Target only; never drives the clock
// - Data line pulled low or released only
// - Answers target address 0x47 only
// - Data changes on low clock; start/stop
// - Master sends address plus direction bit
// - Matching address acknowledged with low data
// - Stop frees bus and ends access
// - Two bytes after address set pointer
// - Every data word is two bytes
// - Pointer advances after each written word and each read word the master acknowledges
// - Pointer never advances when the access starts in table space
// - Reads use address write then restart
// - Stop needed before other direction changes
// - Byte order within word is selectable
`timescale 1ns/100ps
module sra_device (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Link
   sra_if.dev bus,
   // Register side
   input wire logic swap_bytes,
   output logic wr_stb,
   output logic rd_stb,
   output logic [15:0] reg_addr,
   output logic [15:0] wr_data,
   input wire logic [15:0] rd_data,
   output logic busy
);
   typedef enum {S_IDLE, S_DEVADR, S_DEVACK, S_RX, S_RXACK, S_TX, S_TXACK,
      S_IGNORE} sra_state_t;
   sra_state_t state;
   logic [1:0] scl_s, sda_s;
   logic scl_q, sda_q;
   logic [7:0] shreg;
   logic [2:0] bitcnt;
   logic [1:0] rx_bytes;
   logic hi_done;
   logic [7:0] lo_keep;
   logic [15:0] tx_word;
   logic tx_second;
   logic read_dir;
   logic drive_low;
   logic addr_set;
   logic [15:0] start_addr;
   wire scl_rise = scl_s[1] && !scl_q;
   wire scl_fall = !scl_s[1] && scl_q;
   wire start_c = scl_s[1] && scl_q && sda_q && !sda_s[1];
   wire stop_c = scl_s[1] && scl_q && !sda_q && sda_s[1];

   // Pointer step rule: table space holds the pointer
   function automatic logic [15:0] next_ptr(input logic [15:0] a,
      input logic [15:0] base);
      next_ptr = (base >= sra_pkg::TABLE_BASE) ? a : a + 16'h0001;
   endfunction

   // Two-flop synchronisers on both pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (clk_en) begin
         scl_s <= {scl_s[0], bus.scl};
         sda_s <= {sda_s[0], bus.sda};
         scl_q <= scl_s[1];
         sda_q <= sda_s[1];
      end
   end

   // Open drain: output always low, only the enable toggles
   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = drive_low;
   assign busy = (state != S_IDLE) && (state != S_IGNORE);

   // Protocol engine
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= S_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         rx_bytes <= 2'h0;
         hi_done <= 1'b0;
         lo_keep <= 8'h00;
         tx_word <= 16'h0000;
         tx_second <= 1'b0;
         read_dir <= 1'b0;
         drive_low <= 1'b0;
         addr_set <= 1'b0;
         start_addr <= 16'h0000;
         reg_addr <= 16'h0000;
         wr_data <= 16'h0000;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
      end else if (clk_en) begin
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         if (stop_c) begin
            state <= S_IDLE;
            drive_low <= 1'b0;
            addr_set <= 1'b0;
         end else if (start_c) begin
            // Repeated start keeps pointer so a read can follow
            state <= S_DEVADR;
            bitcnt <= 3'h0;
            drive_low <= 1'b0;
         end else begin
            case (state)
               S_DEVADR: if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s[1]};
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     read_dir <= sda_s[1];
                     state <= S_DEVACK;
                  end
               end
               S_DEVACK: if (scl_fall) begin
                  // Address sits above the direction bit in the byte
                  if (shreg[7:1] == sra_pkg::TARGET_ADDR) begin
                     drive_low <= 1'b1;
                     state <= read_dir ? S_TXACK : S_RXACK;
                     rx_bytes <= 2'h0;
                     hi_done <= 1'b0;
                     if (read_dir) begin
                        rd_stb <= 1'b1;
                        tx_second <= 1'b0;
                     end
                  end else begin
                     state <= S_IGNORE;
                  end
               end
               S_RX: if (scl_rise) begin
                  shreg <= {shreg[6:0], sda_s[1]};
                  bitcnt <= bitcnt + 3'h1;
                  if (bitcnt == 3'h7) begin
                     state <= S_RXACK;
                     if (!addr_set && rx_bytes == 2'h1) begin
                        // Low address byte joins the stored high byte
                        reg_addr[7:0] <= {shreg[6:0], sda_s[1]};
                        start_addr <= {reg_addr[15:8], shreg[6:0],
                           sda_s[1]};
                        addr_set <= 1'b1;
                     end else if (!addr_set) begin
                        rx_bytes <= 2'h1;
                        reg_addr[15:8] <= {shreg[6:0], sda_s[1]};
                     end else if (!hi_done) begin
                        hi_done <= 1'b1;
                        lo_keep <= {shreg[6:0], sda_s[1]};
                     end else begin
                        hi_done <= 1'b0;
                        wr_data <= swap_bytes ? {shreg[6:0], sda_s[1],
                           lo_keep} : {lo_keep, shreg[6:0], sda_s[1]};
                        wr_stb <= 1'b1;
                     end
                     drive_low <= 1'b0;
                  end
               end
               S_RXACK: if (scl_fall) begin
                  if (drive_low) begin
                     drive_low <= 1'b0;
                     state <= S_RX;
                     bitcnt <= 3'h0;
                     if (wr_stb || (addr_set && !hi_done && bitcnt == 3'h0
                        && rx_bytes == 2'h3))
                        reg_addr <= reg_addr;
                  end else begin
                     drive_low <= 1'b1; // Acknowledge each byte
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     bitcnt <= bitcnt + 3'h1;
                     if (bitcnt == 3'h7) begin
                        drive_low <= 1'b0;
                        state <= S_TXACK;
                     end else begin
                        drive_low <= !shreg[3'h6 - bitcnt];
                     end
                  end
               end
               S_TXACK: begin
                  if (scl_rise && !drive_low) begin
                     if (sda_s[1]) begin
                        state <= S_IGNORE;
                     end else if (!tx_second) begin
                        // Word acknowledged: step pointer, fetch next
                        reg_addr <= next_ptr(reg_addr, start_addr);
                        rd_stb <= 1'b1;
                     end
                  end else if (scl_fall) begin
                     // First byte comes fresh, second from the held word
                     state <= S_TX;
                     bitcnt <= 3'h0;
                     tx_second <= !tx_second;
                     if (!tx_second) begin
                        shreg <= swap_bytes ? rd_data[7:0] : rd_data[15:8];
                        tx_word <= rd_data;
                        drive_low <= swap_bytes ? !rd_data[7]
                           : !rd_data[15];
                     end else begin
                        shreg <= swap_bytes ? tx_word[15:8]
                           : tx_word[7:0];
                        drive_low <= swap_bytes ? !tx_word[15]
                           : !tx_word[7];
                     end
                  end
               end
               default: ;
            endcase
            // Write pointer advances one cycle after each full word
            if (wr_stb)
               reg_addr <= next_ptr(reg_addr, start_addr);
         end
      end
   end
endmodule // sra_device

/* File: verilog/sra_host.sv */
// Host end: two-wire master issuing register writes and reads
`timescale 1ns/100ps
module sra_host (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Link
   sra_if.host bus,
   // Command side
   input wire logic req,
   input wire logic req_read,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_data,
   output logic ack,
   output logic nack,
   output logic [15:0] rsp_data,
   output logic busy
);
   typedef enum {H_IDLE, H_START, H_BIT, H_RESTART, H_STOP} sra_hstate_t;
   sra_hstate_t state;
   logic [1:0] sda_s;
   logic [7:0] div;
   logic phase; // 0 low half, 1 high half
   logic [7:0] tx;
   logic [3:0] bitn;
   logic [2:0] byten;
   logic rd;
   logic sda_drv;
   logic scl_drv;
   logic restarted;
   logic nacked;
   logic [15:0] rx;
   wire tick = (div == sra_pkg::HALF_PERIOD_8 - 8'h01);

   // Byte to send for each position of the sequence
   function automatic logic [7:0] pick(input logic [2:0] n,
      input logic r, input logic rs, input logic [15:0] a,
      input logic [15:0] d);
      case (n)
         3'h0: pick = {sra_pkg::TARGET_ADDR, r && rs};
         3'h1: pick = a[15:8];
         3'h2: pick = a[7:0];
         3'h3: pick = d[15:8];
         default: pick = d[7:0];
      endcase
   endfunction

   // Sync of the returned data line
   always_ff @(posedge clk) begin
      if (!rst_n)
         sda_s <= 2'h3;
      else if (clk_en)
         sda_s <= {sda_s[0], bus.sda};
   end

   assign bus.scl_o = 1'b0;
   assign bus.scl_oe = !scl_drv;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe = !sda_drv;
   assign busy = (state != H_IDLE);

   // Bit engine: sda only moves while scl is low, except start/stop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= H_IDLE;
         div <= 8'h00;
         phase <= 1'b0;
         tx <= 8'h00;
         bitn <= 4'h0;
         byten <= 3'h0;
         rd <= 1'b0;
         sda_drv <= 1'b1;
         scl_drv <= 1'b1;
         restarted <= 1'b0;
         nacked <= 1'b0;
         rx <= 16'h0000;
         rsp_data <= 16'h0000;
         ack <= 1'b0;
         nack <= 1'b0;
      end else if (clk_en) begin
         ack <= 1'b0;
         nack <= 1'b0;
         div <= tick ? 8'h00 : div + 8'h01;
         case (state)
            H_IDLE: if (req) begin
               rd <= req_read;
               restarted <= 1'b0;
               nacked <= 1'b0;
               byten <= 3'h0;
               sda_drv <= 1'b0; // Start: data falls with clock high
               state <= H_START;
               div <= 8'h00;
            end
            H_START, H_RESTART: if (tick) begin
               scl_drv <= 1'b0;
               phase <= 1'b0;
               bitn <= 4'h0;
               tx <= pick(byten, rd, restarted, req_addr, req_data);
               state <= H_BIT;
            end
            H_BIT: if (tick) begin
               if (!phase) begin
                  // Data was set mid low half; now raise the clock
                  scl_drv <= 1'b1;
                  phase <= 1'b1;
               end else begin
                  scl_drv <= 1'b0;
                  phase <= 1'b0;
                  if (bitn < 4'h8) begin
                     tx <= {tx[6:0], 1'b0};
                     rx <= {rx[14:0], sda_s[1]};
                     bitn <= bitn + 4'h1;
                  end else begin
                     bitn <= 4'h0;
                     if (sda_s[1] && !(rd && restarted
                        && byten != 3'h0)) begin
                        nacked <= 1'b1;
                        state <= H_STOP;
                     end else if (rd && restarted && byten == 3'h2) begin
                        rsp_data <= rx;
                        state <= H_STOP;
                     end else if (rd && !restarted && byten == 3'h2) begin
                        restarted <= 1'b1;
                        byten <= 3'h0;
                        state <= H_RESTART;
                        sda_drv <= 1'b1;
                     end else if (!rd && byten == 3'h4) begin
                        state <= H_STOP;
                     end else begin
                        byten <= byten + 3'h1;
                        tx <= pick(byten + 3'h1, rd, restarted, req_addr,
                           req_data);
                     end
                  end
               end
            end
            H_STOP: if (tick) begin
               // Pull data low, raise clock, then release data
               if (scl_drv == 1'b0 && sda_drv) begin
                  sda_drv <= 1'b0;
               end else if (scl_drv == 1'b0) begin
                  scl_drv <= 1'b1;
               end else if (!sda_drv) begin
                  sda_drv <= 1'b1;
               end else begin
                  ack <= !nacked;
                  nack <= nacked;
                  state <= H_IDLE;
               end
            end
            default: state <= H_IDLE;
         endcase
         // Restart: release data while clock low, raise clock, then fall
         if (state == H_RESTART && !tick && div == 8'h3f) begin
            scl_drv <= 1'b1;
         end else if (state == H_RESTART && div == 8'h5f) begin
            sda_drv <= 1'b0;
         end
         // Data moves mid low half, clear of both clock edges
         if (state == H_BIT && !phase && div == 8'h3f) begin
            if (bitn < 4'h8)
               sda_drv <= (rd && restarted && byten != 3'h0) ? 1'b1 : tx[7];
            else
               sda_drv <= !(rd && restarted && byten == 3'h1);
         end
      end
   end
endmodule // sra_host

/* File: verif/sra_monitor.sv */
// Protocol checker for the two-wire register access link
`timescale 1ns/100ps
module sra_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link drivers and resolved lines
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_s_o,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   logic [9:0] lo_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Length of the low clock phase, so a stuck clock is caught
   always_ff @(posedge clk) begin
      if (!rst_n || scl) begin
         lo_cnt <= 10'h000;
      end else if (lo_cnt != 10'h3ff) begin
         lo_cnt <= lo_cnt + 10'h001;
      end
   end
   dev_pull_low_a: assert property (sda_s_oe |-> !sda_s_o)
      else $error("device drives data high");
   host_pull_low_a: assert property (scl_oe |-> !scl_o && !sda_m_o)
      else $error("host drives a line high");
   dev_hold_high_a: assert property (scl && $past(scl)
      |-> $stable(sda_s_oe))
      else $error("device data moved while clock high");
   dev_turn_low_a: assert property ($rose(sda_s_oe) |-> !scl)
      else $error("device pulled data with clock high");
   start_quiet_a: assert property ($fell(sda) && scl
      && $past(scl) |-> !sda_s_oe)
      else $error("device made a start");
   stop_free_a: assert property ($rose(sda) && scl
      && $past(scl) |=> !sda_s_oe [*8])
      else $error("device drives after stop");
   clk_high_min_a: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   clk_low_max_a: assert property (lo_cnt < 10'h3e8)
      else $error("clock stuck low");
   reset_idle_a: assert property (@(posedge clk) disable iff (1'b0)
      !rst_n |=> !sda_s_oe && !scl_oe) else $error("line driven in reset");
   // Main scenarios: acknowledge, start, stop
   cover property (sda_s_oe && $rose(scl));
   cover property ($fell(sda) && scl && $past(scl));
   cover property ($rose(sda) && scl && $past(scl));
endmodule // sra_monitor

/* File: verif/i2c_register_access_slave_tb.sv */
// Self-checking bench for the two-wire register access link
`timescale 1ns/100ps
module i2c_register_access_slave_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic swap_bytes = 1'b0;
   logic req = 1'b0;
   logic req_read = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_data = 16'h0000;
   logic [15:0] rd_data = 16'h0000;
   logic ack, nack, h_busy, d_busy, d_busy_b;
   logic wr_stb, rd_stb, wr_stb_b, rd_stb_b;
   logic [15:0] rsp_data, reg_addr, wr_data, reg_addr_b, wr_data_b, q;
   logic [31:0] wq[$];
   logic [31:0] wq_b[$];
   int n_mismatch = 0;
   int compares = 0;
   sra_if link ();
   sra_if link_b ();
   sra_host sra_host_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
      .bus(link), .req(req), .req_read(req_read), .req_addr(req_addr),
      .req_data(req_data), .ack(ack), .nack(nack), .rsp_data(rsp_data),
      .busy(h_busy));
   sra_device sra_device_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
      .bus(link), .swap_bytes(swap_bytes), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data),
      .busy(d_busy));
   // Second device faces the bench's own bit-level driver
   sra_device sra_device_inst_b (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
      .bus(link_b), .swap_bytes(1'b0), .wr_stb(wr_stb_b),
      .rd_stb(rd_stb_b), .reg_addr(reg_addr_b), .wr_data(wr_data_b),
      .rd_data(16'h0000), .busy(d_busy_b));
   sra_monitor sra_monitor_inst (.clk(clk), .rst_n(rst_n),
      .scl_o(link.scl_o), .scl_oe(link.scl_oe), .sda_m_o(link.sda_m_o),
      .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o),
      .sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda));
   always #10 clk = ~clk;
   // Register side: log writes, answer reads the cycle after the strobe
   always @(posedge clk) begin
      if (wr_stb === 1'b1) wq.push_back({reg_addr, wr_data});
      if (wr_stb_b === 1'b1) wq_b.push_back({reg_addr_b, wr_data_b});
      if (rd_stb === 1'b1) rd_data <= reg_addr ^ 16'h5a5a;
   end
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One word through the host; req drops once taken, data held to ack
   task automatic host_op(input logic rd, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      req_read <= rd;
      req_addr <= a;
      req_data <= d;
      req <= 1'b1;
      while (h_busy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      while (ack !== 1'b1 && nack !== 1'b1 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      check("done", {31'h0, ack}, 32'h1);
      check("nack", {31'h0, nack}, 32'h0);
      r = rsp_data;
      @(posedge clk);
   endtask
   // Half a link clock period (4 clk cycles) with both lines set
   task automatic half(input logic c, input logic d);
      link_b.scl_oe <= !c;
      link_b.sda_m_oe <= !d;
      repeat (4) @(posedge clk);
   endtask
   task automatic send_b(input logic [7:0] b, input logic exp_ack);
      for (int i = 7; i >= 0; i--) begin
         half(1'b0, b[i]);
         half(1'b1, b[i]);
      end
      half(1'b0, 1'b1);
      half(1'b1, 1'b1);
      check("ack_b", {31'h0, link_b.sda}, {31'h0, exp_ack});
   endtask
   task automatic start_b();
      half(1'b1, 1'b1);
      half(1'b1, 1'b0);
      half(1'b0, 1'b0);
   endtask
   task automatic stop_b();
      half(1'b0, 1'b0);
      half(1'b1, 1'b0);
      half(1'b1, 1'b1);
   endtask
   // Address write byte, then register address and two words
   task automatic burst_b(input logic [47:0] bytes);
      start_b();
      send_b(8'h8e, 1'b0);
      for (int i = 5; i >= 0; i--) begin
         send_b(bytes[i*8+:8], 1'b0);
      end
      stop_b();
   endtask
   // Hang guard, well above the expected run of about 53500 cycles
   initial begin
      repeat (95000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      link_b.scl_o = 1'b0;
      link_b.sda_m_o = 1'b0;
      link_b.scl_oe = 1'b0;
      link_b.sda_m_oe = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      host_op(1'b0, 16'h1234, 16'habcd, q);
      check("wr", wq.pop_front(), 32'h1234abcd);
      swap_bytes <= 1'b1;
      host_op(1'b0, 16'h0100, 16'h1357, q);
      check("wr_swap", wq.pop_front(), 32'h01005713);
      host_op(1'b1, 16'hc004, 16'h0000, q);
      check("rd_swap", {16'h0, q}, 32'h00005e9a);
      swap_bytes <= 1'b0;
      host_op(1'b1, 16'h0042, 16'h0000, q);
      check("rd", {16'h0, q}, {16'h0, 16'h0042 ^ 16'h5a5a});
      check("wr_left", 32'(wq.size()), 32'h0);
      start_b();
      send_b(8'h90, 1'b1);
      send_b(8'h00, 1'b1);
      stop_b();
      check("b_none", 32'(wq_b.size()), 32'h0);
      burst_b(48'h002011223344);
      check("b_w0", wq_b.pop_front(), 32'h00201122);
      check("b_w1", wq_b.pop_front(), 32'h00213344);
      burst_b(48'hc00055667788);
      check("b_t0", wq_b.pop_front(), 32'hc0005566);
      check("b_t1", wq_b.pop_front(), 32'hc0007788);
      wrap_up();
   end
endmodule // i2c_register_access_slave_tb
